// file: dv/pfs_led_pullup.sv
// Partner model: pull-up resistor and indicator on the open-drain charge status pin.
// Assumes the supervisor drives low only while its output enable is high.
`timescale 1ns/100ps
module pfs_led_pullup (
  // From the supervisor
  input wire logic chargeStatusOut,
  input wire logic chargeStatusOe,
  // Resolved pin level
  output logic ledLevel
);
  // Released pin goes to the pull-up level, never to the last driven value
  assign ledLevel = chargeStatusOe ? chargeStatusOut : 1'b1;
endmodule

// file: dv/pfs_supervisor_tb_top.sv
// Testbench of the supervisor: APB tasks, pin stimulus and directed checks.
// Assumes shortened timing parameters so the run stays a few hundred cycles.
`timescale 1ns/100ps
module pfs_supervisor_tb_top;
  import pfs_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic pready, pslverr, chargeStatusOut, chargeStatusOe, irq, ledLevel;
  pfs_pins_s pins = '0;
  pfs_fault_s switchOff;
  int err_total = 0, check_count = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  pfs_supervisor #(.SHUTDOWN_CYC(20), .DETECT_CYC(50), .SLOW_HALF_CYC(16), .FAST_HALF_CYC(4)) DUT (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .switchOff(switchOff), .chargeStatusOut(chargeStatusOut), .chargeStatusOe(chargeStatusOe), .irq(irq));
  pfs_led_pullup PULL (.chargeStatusOut(chargeStatusOut), .chargeStatusOe(chargeStatusOe), .ledLevel(ledLevel));
  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task w(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task ck(logic [31:0] g, logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task rc(logic [7:0] a, logic [31:0] e);
    apb(0, a, 0);
    ck(rd, e);
  endtask
  task rel;
    pins.groupEnableHigh <= 0;
    w(6);
    pins.groupEnableHigh <= 1;
    w(6);
  endtask
  // Counts pin edges over 40 cycles
  task blink(int lo, int hi);
    int n;
    logic p;
    n = 0;
    #1 p = ledLevel;
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (ledLevel !== p) n++;
      p = ledLevel;
    end
    @(posedge clk_sys);
    ck(32'(n >= lo && n <= hi), 1);
  endtask
  initial begin
    w(10);
    rst <= 0;
    rc(8'h0C, 32'h2);
    apb(0, 8'h1C, 0);
    ck(er, 1);
    pins.enablePinHigh <= 1;
    pins.groupEnableHigh <= 1;
    w(6);
    apb(1, 8'h00, 32'h3);
    apb(1, 8'h04, 32'h2);
    apb(1, 8'h08, 32'hA);
    pins.ledOvp <= 1;
    w(6);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'hA);
    rc(8'h00, 32'h3);
    pins.ledOvp <= 0;
    pins.enablePinHigh <= 0;
    w(6);
    // Blink select is a charger setting and survives; the class E bit and the class I aux bits clear
    rc(8'h00, 32'h1);
    rc(8'h08, 32'h0);
    pins.enablePinHigh <= 1;
    w(6);
    // Detection run with a result, then with a timeout
    apb(1, 8'h18, 32'h11);
    apb(1, 8'h0C, 32'h2);
    rc(8'h0C, 32'h3);
    pins.detectResult <= 3'h5;
    pins.detectDone <= 1;
    w(6);
    rc(8'h0C, 32'hA2);
    ck(irq, 1);
    pins.detectDone <= 0;
    pins.inputBelow3p3 <= 1;
    w(6);
    rc(8'h0C, 32'h2);
    pins.inputBelow3p3 <= 0;
    w(6);
    apb(1, 8'h14, 32'h1F);
    apb(1, 8'h0C, 32'h2);
    // Still running well inside the limit, ended once past it
    w(30);
    rc(8'h0C, 32'h3);
    w(25);
    rc(8'h0C, 32'h2);
    // Drop the timeout event so the next irq check can fail
    apb(1, 8'h14, 32'h1F);
    w(1);
    ck(irq, 0);
    // Protection latches
    pins.boostPrechargeDone <= 1;
    pins.boostFbLow <= 1;
    w(6);
    rc(8'h10, 32'h1);
    ck(irq, 1);
    pins.boostFbLow <= 0;
    rel();
    rc(8'h10, 32'h0);
    apb(1, 8'h14, 32'h1F);
    pins.boostBelowSys <= 1;
    w(15);
    pins.boostBelowSys <= 0;
    w(6);
    pins.boostBelowSys <= 1;
    w(15);
    rc(8'h10, 32'h0);
    w(10);
    rc(8'h10, 32'h1);
    pins.boostBelowSys <= 0;
    pins.internalBelow1p3 <= 1;
    w(6);
    pins.internalBelow1p3 <= 0;
    w(6);
    rc(8'h10, 32'h0);
    pins.boostOverload <= 1;
    w(30);
    rc(8'h10, 32'h8);
    pins.boostOverload <= 0;
    rel();
    pins.buckBoostFbLow <= 1;
    pins.firstBuckFbLow <= 1;
    w(6);
    rc(8'h10, 32'h0);
    pins.buckBoostSoftStartDone <= 1;
    w(6);
    rc(8'h10, 32'h2);
    pins.firstBuckSoftStartDone <= 1;
    w(6);
    rc(8'h10, 32'h6);
    ck(32'(switchOff), 32'h6);
    pins.buckBoostFbLow <= 0;
    pins.firstBuckFbLow <= 0;
    rel();
    // Indicator patterns; steady mode first
    apb(1, 8'h00, 32'h0);
    ck(ledLevel, 1);
    pins.charging <= 1;
    w(6);
    ck(ledLevel, 0);
    apb(1, 8'h00, 32'h1);
    blink(2, 3);
    pins.chargeAbnormal <= 1;
    w(6);
    blink(9, 10);
    apb(1, 8'h00, 32'h0);
    blink(9, 10);
    complete_run();
  end
endmodule

// file: rtl/pfs_delay_timer.sv
// Delay timer that expires after a condition has held without a break.
// Assumes trigger comes from logic on clk_sys; CYCLES is at least 2.
`timescale 1ns/100ps
module pfs_delay_timer #(
  parameter int unsigned CYCLES = pfs_pkg::SHUTDOWN_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Condition and expiry
  input wire logic trigger,
  output logic expired
);
  import pfs_pkg::*;

  logic [31:0] cnt_r;
  logic expired_r;

  // ****************************************
  // Counter
  // ****************************************
  // Saturates after expiry so the pulse comes only once per run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
    end else if (!trigger) begin
      cnt_r <= 32'h0;
    end else if (cnt_r != CYCLES) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      expired_r <= 1'h0;
    end else begin
      expired_r <= trigger && (cnt_r == CYCLES - 1);
    end
  end

  assign expired = expired_r;

  // ****************************************
  // Checks
  // ****************************************
  AST_TIMER_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
    !trigger |=> (cnt_r == 32'h0))
    else $error("delay timer did not restart when its condition cleared");

  AST_TIMER_CAUSE: assert property (@(posedge clk_sys) disable iff (rst)
    expired_r |-> $past(trigger) && ($past(cnt_r) == CYCLES - 1))
    else $error("delay timer expired without a full interval");

endmodule

// file: rtl/pfs_pkg.sv
// Shared constants, field layouts and carrier types of the PMU fault and status supervisor.
// Assumes a single 20 MHz system clock; every pin input arrives asynchronously.
package pfs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int unsigned SHUTDOWN_DELAY_MS = 100;
  localparam int unsigned SHUTDOWN_DELAY_CYC = SHUTDOWN_DELAY_MS * CYC_PER_MS;
  localparam int unsigned DETECT_LIMIT_MS = 200;
  // Longest time, so rounded down
  localparam int unsigned DETECT_LIMIT_CYC = DETECT_LIMIT_MS * CYC_PER_MS;
  localparam int unsigned SLOW_BLINK_PERIOD_MS = 2000;
  localparam int unsigned SLOW_BLINK_HALF_CYC = SLOW_BLINK_PERIOD_MS * CYC_PER_MS / 2;
  localparam int unsigned FAST_BLINK_PERIOD_MS = 250;
  localparam int unsigned FAST_BLINK_HALF_CYC = FAST_BLINK_PERIOD_MS * CYC_PER_MS / 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam logic [7:0] ADDR_CHARGER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEEPALIVE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_AUX_SETTINGS = 8'h08;
  localparam logic [7:0] ADDR_TYPE_DETECT = 8'h0C;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CC_BLINK_BIT = 0;
  localparam int CC_INTCTL_BIT = 1;
  localparam int KA_HOLD_BIT = 1;
  localparam int AUX_W = 4;
  localparam int TD_RUN_BIT = 0;
  localparam int TD_PRI_BIT = 1;
  localparam int TD_SEC_BIT = 2;
  localparam int TD_RES_LSB = 5;
  localparam int RES_W = 3;
  localparam int FAULT_W = 4;
  localparam int IRQ_W = 5;
  localparam int IRQ_DETECT_BIT = 4;
  localparam logic [1:0] TD_SEL_RESET = 2'h1;
  localparam logic [2:0] RESULT_NONE = 3'h0;
  localparam logic [AUX_W-1:0] AUX_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    DET_IDLE = 1'h0,
    DET_RUN  = 1'h1
  } pfs_det_e;

  // Asynchronous pin inputs from the analogue side
  typedef struct packed {
    logic enablePinHigh;
    logic groupEnableHigh;
    logic internalBelow1p3;
    logic internalBelow2p4;
    logic inputBelow3p3;
    logic batteryBelow1p3;
    logic overTemp;
    logic ledOvp;
    logic boostBelowSys;
    logic boostBelowAbs;
    logic boostSoftStartDone;
    logic boostFbLow;
    logic boostPrechargeDone;
    logic boostOverload;
    logic buckBoostFbLow;
    logic buckBoostSoftStartDone;
    logic firstBuckFbLow;
    logic firstBuckSoftStartDone;
    logic charging;
    logic chargeAbnormal;
    logic detectDone;
    logic [2:0] detectResult;
  } pfs_pins_s;

  // Latched switch-off commands; boostOff is bit 0
  typedef struct packed {
    logic pmuShutdown;
    logic firstBuckOff;
    logic buckBoostOff;
    logic boostOff;
  } pfs_fault_s;

endpackage

// file: rtl/pfs_supervisor.sv
// Top of the PMU fault and status supervisor: reset classes, charger type detection,
// charge indicator and converter protection latches, with an APB register slave.
// Assumes analogue comparators and detector drive pins asynchronously; APB on clk_sys.
//
// Summary of operation
// - Class E bits clear while enable pin low or internal supply below 1.3V.
// - Interrupt-control bit of charger control register belongs to class E.
// - Type detect register resets on input below 3.3V or internal below 1.3V.
// - Class H bit clears on enable low, low supplies, any protection, overtemperature, or LED overvoltage.
// - Class I bits clear like class H, but LED overvoltage does not clear them.
// - Three-bit charger type result changes only when a detection run finishes or the type detect register resets.
// - Detect running flag stays high for the whole detection run.
// - Indicator floats when idle; charging drives low or blinks at 0.5Hz.
// - Abnormal charge conditions blink the indicator at 4Hz regardless of mode.
// - Primary type detection always completes within 200ms of its start.
// - Boost output undervoltage switches boost off after 100ms and latches.
// - Boost feedback low after pre-charge switches boost off at once.
// - Boost overload held 100ms without break shuts down the whole unit.
// - Buck-boost feedback low after soft-start switches it off, latched.
// - First buck feedback low after soft-start switches it off, latched.
`timescale 1ns/100ps
module pfs_supervisor #(
  parameter int unsigned SHUTDOWN_CYC = pfs_pkg::SHUTDOWN_DELAY_CYC,
  parameter int unsigned DETECT_CYC = pfs_pkg::DETECT_LIMIT_CYC,
  parameter int unsigned SLOW_HALF_CYC = pfs_pkg::SLOW_BLINK_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = pfs_pkg::FAST_BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfs_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [pfs_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pfs_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analogue side pins
  input wire pfs_pkg::pfs_pins_s pins,
  // Switch-off commands
  output pfs_pkg::pfs_fault_s switchOff,
  // Open-drain charge status indicator
  output logic chargeStatusOut,
  output logic chargeStatusOe,
  // Interrupt
  output logic irq
);
  import pfs_pkg::*;

  localparam int PIN_W = $bits(pfs_pins_s);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync2_r;
  logic [PIN_W-1:0] sync3_r;
  logic [PIN_W-1:0] pinFilt_r;
  pfs_pins_s pin;

  assign pinRaw = pins;

  // Three flops; a change counts once the last two agree
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sync1_r[i] <= 1'h0;
        sync2_r[i] <= 1'h0;
        sync3_r[i] <= 1'h0;
        pinFilt_r[i] <= 1'h0;
      end else begin
        sync1_r[i] <= pinRaw[i];
        sync2_r[i] <= sync1_r[i];
        sync3_r[i] <= sync2_r[i];
        if (sync2_r[i] == sync3_r[i]) begin
          pinFilt_r[i] <= sync3_r[i];
        end
      end
    end
  end

  assign pin = pfs_pins_s'(pinFilt_r);

  // ****************************************
  // APB slave
  // ****************************************
  logic pready_r;
  logic pslverr_r;
  logic [APB_DATA_W-1:0] prdata_r;
  logic apbAccess;
  logic apbDone;
  logic wrLow;
  logic [APB_DATA_W-1:0] rdData;
  logic rdHit;

  assign apbAccess = psel && penable;
  assign apbDone = apbAccess && pready_r;
  // Every register fits in byte lane 0
  assign wrLow = apbDone && pwrite && pstrb[0];

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apbAccess && !pready_r;
      pslverr_r <= apbAccess && !pready_r && !rdHit;
      if (apbAccess && !pready_r && !pwrite) begin
        prdata_r <= rdData;
      end else if (apbDone) begin
        prdata_r <= 32'h0;
      end
    end
  end

  // ****************************************
  // Reset classes and settings
  // ****************************************
  logic blinkSel_r;
  logic intCtl_r;
  logic keepHold_r;
  logic [AUX_W-1:0] aux_r;
  pfs_fault_s fault_r;
  logic classEClr;
  logic classHClr;
  logic classIClr;
  logic protCore;

  assign protCore = |fault_r;
  assign classEClr = !pin.enablePinHigh || pin.internalBelow1p3;
  assign classIClr = !pin.enablePinHigh || pin.internalBelow2p4 || pin.batteryBelow1p3 ||
                     protCore || pin.overTemp;
  assign classHClr = classIClr || pin.ledOvp;

  // Charger control: blink mode and the class E interrupt-control bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blinkSel_r <= 1'h0;
      intCtl_r <= 1'h0;
    end else begin
      if (wrLow && paddr == ADDR_CHARGER_CTRL) begin
        blinkSel_r <= pwdata[CC_BLINK_BIT];
      end
      if (classEClr) begin
        intCtl_r <= 1'h0;
      end else if (wrLow && paddr == ADDR_CHARGER_CTRL) begin
        intCtl_r <= pwdata[CC_INTCTL_BIT];
      end
    end
  end

  // Keep-alive hold bit (class H) and auxiliary bits (class I)
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keepHold_r <= 1'h0;
      aux_r <= AUX_RESET;
    end else begin
      if (classHClr) begin
        keepHold_r <= 1'h0;
      end else if (wrLow && paddr == ADDR_KEEPALIVE_CTRL) begin
        keepHold_r <= pwdata[KA_HOLD_BIT];
      end
      if (classIClr) begin
        aux_r <= AUX_RESET;
      end else if (wrLow && paddr == ADDR_AUX_SETTINGS) begin
        aux_r <= pwdata[AUX_W-1:0];
      end
    end
  end

  // ****************************************
  // Charger type detection
  // ****************************************
  pfs_det_e detState_r;
  logic [1:0] detSel_r;
  logic [RES_W-1:0] detResult_r;
  logic [31:0] detCnt_r;
  logic detClr;
  logic detStart;
  logic detFinish;
  logic detTimeout;
  logic detRun;

  assign detClr = pin.inputBelow3p3 || pin.internalBelow1p3;
  assign detRun = (detState_r == DET_RUN);
  assign detStart = wrLow && paddr == ADDR_TYPE_DETECT && !detRun &&
                    (pwdata[TD_PRI_BIT] || pwdata[TD_SEC_BIT]);
  // Forced end when the count reaches the limit minus one keeps the run at most DETECT_CYC cycles
  assign detTimeout = (detCnt_r == DETECT_CYC - 1);
  assign detFinish = detRun && !detClr && (pin.detectDone || detTimeout);

  // Run state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detState_r <= DET_IDLE;
    end else if (detClr) begin
      detState_r <= DET_IDLE;
    end else begin
      unique case (detState_r)
        DET_IDLE: begin
          if (detStart) begin
            detState_r <= DET_RUN;
          end
        end
        DET_RUN: begin
          if (detFinish) begin
            detState_r <= DET_IDLE;
          end
        end
      endcase
    end
  end

  // Run length counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detCnt_r <= 32'h0;
    end else if (detClr || !detRun || detFinish) begin
      detCnt_r <= 32'h0;
    end else begin
      detCnt_r <= detCnt_r + 32'h1;
    end
  end

  // Selection bits and result; a timed-out run reports no charger
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detSel_r <= TD_SEL_RESET;
      detResult_r <= RESULT_NONE;
    end else if (detClr) begin
      detSel_r <= TD_SEL_RESET;
      detResult_r <= RESULT_NONE;
    end else begin
      if (wrLow && paddr == ADDR_TYPE_DETECT && !detRun) begin
        detSel_r <= pwdata[TD_SEC_BIT:TD_PRI_BIT];
      end
      if (detFinish) begin
        detResult_r <= pin.detectDone ? pin.detectResult : RESULT_NONE;
      end
    end
  end

  // ****************************************
  // Converter protection
  // ****************************************
  logic latchClr;
  logic boostSlowTrip;
  logic boostFastTrip;
  logic buckBoostTrip;
  logic firstBuckTrip;
  logic boostDelayExp;
  logic overloadExp;
  pfs_fault_s faultSet;

  // Supply reset or group enable low releases every latch
  assign latchClr = pin.internalBelow1p3 || !pin.groupEnableHigh;
  assign boostSlowTrip = pin.boostBelowSys || (pin.boostBelowAbs && pin.boostSoftStartDone);
  assign boostFastTrip = pin.boostFbLow && pin.boostPrechargeDone;
  assign buckBoostTrip = pin.buckBoostFbLow && pin.buckBoostSoftStartDone;
  assign firstBuckTrip = pin.firstBuckFbLow && pin.firstBuckSoftStartDone;

  pfs_delay_timer #(
    .CYCLES(SHUTDOWN_CYC)
  ) u_boost_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(boostSlowTrip && !latchClr && !fault_r.boostOff),
    .expired(boostDelayExp)
  );

  pfs_delay_timer #(
    .CYCLES(SHUTDOWN_CYC)
  ) u_overload_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(pin.boostOverload && !latchClr && !fault_r.pmuShutdown),
    .expired(overloadExp)
  );

  assign faultSet.boostOff = boostFastTrip || boostDelayExp;
  assign faultSet.buckBoostOff = buckBoostTrip;
  assign faultSet.firstBuckOff = firstBuckTrip;
  assign faultSet.pmuShutdown = overloadExp;

  // Latches hold until the release condition; release wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_r <= '0;
    end else if (latchClr) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_r | faultSet;
    end
  end

  assign switchOff = fault_r;

  // ****************************************
  // Charge status indicator
  // ****************************************
  logic [31:0] blinkCnt_r;
  logic blinkPhase_r;
  logic blinkWrap;
  logic chgOe_r;
  logic chgOut_r;
  logic [31:0] halfSel;

  assign halfSel = pin.chargeAbnormal ? FAST_HALF_CYC : SLOW_HALF_CYC;
  assign blinkWrap = (blinkCnt_r >= halfSel - 1);

  // Free-running blink base; a rate change may stretch one half period
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      blinkCnt_r <= 32'h0;
      blinkPhase_r <= 1'h0;
    end else if (blinkWrap) begin
      blinkCnt_r <= 32'h0;
      blinkPhase_r <= !blinkPhase_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 32'h1;
    end
  end

  // Enable high pulls the pin low; abnormal outranks the blink mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chgOe_r <= 1'h0;
      chgOut_r <= 1'h0;
    end else begin
      chgOut_r <= 1'h0;
      if (pin.chargeAbnormal) begin
        chgOe_r <= blinkPhase_r;
      end else if (pin.charging) begin
        chgOe_r <= blinkSel_r ? blinkPhase_r : 1'h1;
      end else begin
        chgOe_r <= 1'h0;
      end
    end
  end

  assign chargeStatusOut = chgOut_r;
  assign chargeStatusOe = chgOe_r;

  // ****************************************
  // Interrupts and read mux
  // ****************************************
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqEvent;
  logic [IRQ_W-1:0] irqW1c;
  logic irq_r;

  assign irqEvent = {detFinish, faultSet & ~fault_r & {FAULT_W{!latchClr}}};
  assign irqW1c = (wrLow && paddr == ADDR_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : 5'h00;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqStat_r <= 5'h00;
      irqMask_r <= IRQ_MASK_RESET;
      irq_r <= 1'h0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqW1c) | irqEvent;
      if (wrLow && paddr == ADDR_IRQ_MASK) begin
        irqMask_r <= pwdata[IRQ_W-1:0];
      end
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  assign irq = irq_r;

  // Read data; unmapped offsets answer with an error and zero
  always_comb begin
    rdData = 32'h0;
    rdHit = 1'h1;
    unique case (paddr)
      ADDR_CHARGER_CTRL: begin
        rdData[CC_BLINK_BIT] = blinkSel_r;
        rdData[CC_INTCTL_BIT] = intCtl_r;
      end
      ADDR_KEEPALIVE_CTRL: rdData[KA_HOLD_BIT] = keepHold_r;
      ADDR_AUX_SETTINGS: rdData[AUX_W-1:0] = aux_r;
      ADDR_TYPE_DETECT: begin
        rdData[TD_RES_LSB+RES_W-1:TD_RES_LSB] = detResult_r;
        rdData[TD_SEC_BIT:TD_PRI_BIT] = detSel_r;
        rdData[TD_RUN_BIT] = detRun;
      end
      ADDR_FAULT_STATUS: rdData[FAULT_W-1:0] = fault_r;
      ADDR_IRQ_STATUS: rdData[IRQ_W-1:0] = irqStat_r;
      ADDR_IRQ_MASK: rdData[IRQ_W-1:0] = irqMask_r;
      default: rdHit = 1'h0;
    endcase
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // Checks
  // ****************************************
  AST_CLASS_E_CLEAR: assert property (classEClr |=> !intCtl_r)
    else $error("interrupt-control bit survived a class E reset");

  AST_DETECT_RESET: assert property (detClr |=> !detRun && detResult_r == RESULT_NONE
    && detSel_r == TD_SEL_RESET)
    else $error("type detect register not reset");

  AST_H_CLEAR: assert property (pin.ledOvp |=> !keepHold_r)
    else $error("class H bit kept during LED overvoltage");

  AST_I_LED_ONLY: assert property (!classIClr && pin.ledOvp && !(wrLow && paddr == ADDR_AUX_SETTINGS)
    |=> aux_r == $past(aux_r))
    else $error("class I bits cleared by LED overvoltage alone");

  AST_RESULT_ONLY_AT_END: assert property (!detFinish && !detClr |=> $stable(detResult_r))
    else $error("charger type result changed outside a run end");

  AST_RUN_HELD: assert property (detStart && !detClr |=> detRun [*2])
    else $error("running flag dropped early");

  AST_CHG_FLOAT: assert property (!pin.charging && !pin.chargeAbnormal |=> !chgOe_r)
    else $error("indicator driven while not charging");

  AST_FAST_BLINK: assert property (pin.chargeAbnormal && blinkWrap ##1 pin.chargeAbnormal
    |=> chgOe_r == blinkPhase_r)
    else $error("indicator not following fast blink");

  AST_DETECT_BOUND: assert property (detRun |-> detCnt_r < DETECT_CYC)
    else $error("detection run reached its time limit");

  AST_BOOST_FAST: assert property (boostFastTrip && !latchClr |=> fault_r.boostOff)
    else $error("boost not switched off at once");

  AST_LATCH_HOLD: assert property (fault_r.boostOff && !latchClr |=> fault_r.boostOff)
    else $error("boost off latch released without reset");

  AST_OTHER_CHANNELS: assert property ((buckBoostTrip || firstBuckTrip) && !latchClr
    |=> (fault_r.buckBoostOff || fault_r.firstBuckOff))
    else $error("buck channel not switched off");

  AST_SHUTDOWN_CAUSE: assert property ($rose(fault_r.pmuShutdown) |-> $past(overloadExp))
    else $error("unit shutdown without full overload interval");

  COV_DETECT_DONE: cover property (detRun ##1 detFinish);
  COV_SHUTDOWN: cover property ($rose(fault_r.pmuShutdown));
  COV_SLOW_BLINK: cover property (pin.charging && blinkSel_r && $rose(chgOe_r));
  COV_IRQ: cover property ($rose(irq_r));

endmodule
